//--- hw/secp_defs.vh
// constants for the serial word memory command port
// assumes the includer uses core_clk at 250 mhz; no other context needed
`ifndef SECP_DEFS_VH
`define SECP_DEFS_VH
`define SECP_WORDS      64
`define SECP_ADDR_W     6
`define SECP_DATA_W     16
`define SECP_HDR_BITS   8
`define SECP_OP_READ    2'h2
`define SECP_OP_WRITE   2'h1
`define SECP_OP_ERASE   2'h3
`define SECP_OP_EXT     2'h0
`define SECP_EXT_EN     2'h3
`define SECP_EXT_ERASE_ALL 2'h2
`define SECP_EXT_WRITE_ALL 2'h1
`define SECP_EXT_DIS    2'h0
`define SECP_CLK_NS     4
`define SECP_PROG_MS    10
`define SECP_PROG_CYC   ((`SECP_PROG_MS * 1000000) / `SECP_CLK_NS)
`define SECP_FIFO_DEPTH 8
`endif

//--- hw/secp_fifo.v
// small synchronous fifo with valid and ready on both sides
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module secp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             reset,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;
  wire [AW-1:0]   head_idx;

  // honest full and empty from the occupancy count
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;
  // slot that becomes the head after this edge
  assign head_idx  = do_rd ? rd_ptr + 1'b1 : rd_ptr;

  // storage and pointers
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end

  // registered head word; a push into the head slot bypasses the array,
  // otherwise the first word would lag its valid by one clock
  always @(posedge core_clk)
  begin
    if (reset)
      out_data <= {WIDTH{1'b0}};
    else if (do_wr && (wr_ptr == head_idx))
      out_data <= in_data;
    else
      out_data <= mem[head_idx];
  end
endmodule // secp_fifo

//--- hw/secp_port.v
// serial word memory command port: decoder, array and self-timed programming
// assumes chip_select, serial_clock_in, serial_in are asynchronous pins
`timescale 1ns/1ps
`include "secp_defs.vh"
module secp_port #(
  parameter PROG_CYCLES = `SECP_PROG_CYC
) (
  // clock and reset
  input  wire core_clk,
  input  wire reset,
  // serial pins from the host
  input  wire chip_select,
  input  wire serial_clock_in,
  input  wire serial_in,
  // serial output pin
  output reg  serial_out,
  output reg  serial_out_en,
  // status
  output wire busy,
  output wire program_enabled
);
  // states, one-hot
  localparam ST_IDLE = 6'h01;
  localparam ST_HDR  = 6'h02;
  localparam ST_RD   = 6'h04;
  localparam ST_DATA = 6'h08;
  localparam ST_ARM  = 6'h10;
  localparam ST_WAIT = 6'h20;

  reg  [5:0]  state;
  reg  [1:0]  cs_s, lclk_s, sdat_s;
  reg         lclk_last;
  reg         cs_last;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  hdr;
  reg  [15:0] wdata;
  reg  [16:0] out_sh;
  reg         prog_en;
  reg  [1:0]  kind;
  reg  [5:0]  addr;
  reg  [15:0] pat;
  reg  [31:0] prog_cnt;
  reg  [6:0]  sweep;
  reg         sweeping;
  reg  [15:0] sweep_pat;
  reg  [15:0] mem [0:`SECP_WORDS-1];
  wire        cs;
  wire        lclk_rise;
  wire        cs_fall;
  wire        cs_rise;
  wire        sdat;
  wire        f_valid;
  wire        f_ready;
  wire        f_in_ready;
  wire [23:0] f_data;
  reg         f_push;
  reg  [23:0] f_word;

  // kind codes for a pending program job
  localparam K_ONE = 2'h0;
  localparam K_ALL = 2'h1;

  // extended opcode decode, used for header and action
  function [1:0] ext_of;
    input [7:0] h;
    begin
      ext_of = h[5:4];
    end
  endfunction

  // two-flop synchronisers on every pin
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      cs_s    <= 2'h0;
      lclk_s    <= 2'h0;
      sdat_s    <= 2'h0;
      lclk_last <= 1'b0;
      cs_last <= 1'b0;
    end
    else
    begin
      cs_s    <= {cs_s[0], chip_select};
      lclk_s    <= {lclk_s[0], serial_clock_in};
      sdat_s    <= {sdat_s[0], serial_in};
      lclk_last <= lclk_s[1];
      cs_last <= cs_s[1];
    end
  end

  assign cs      = cs_s[1];
  assign sdat      = sdat_s[1];
  assign lclk_rise = lclk_s[1] & ~lclk_last & cs;
  assign cs_fall = cs_last & ~cs;
  assign cs_rise = cs & ~cs_last;

  // program jobs pass through a small queue; a job that arrives while it is full is dropped
  secp_fifo #(.WIDTH(24), .DEPTH(`SECP_FIFO_DEPTH), .AW(3)) u_jobs (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (f_word),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // the programmer accepts a job only when idle, so back-pressure is real
  assign f_ready         = ~sweeping & (prog_cnt == 32'h0);
  assign busy            = sweeping | (prog_cnt != 32'h0) | f_valid;
  assign program_enabled = prog_en;

  // command sequencer
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
      hdr     <= 8'h00;
      wdata   <= 16'h0000;
      out_sh  <= 17'h1ffff;
      prog_en <= 1'b0;
      kind    <= K_ONE;
      addr    <= 6'h00;
      pat     <= 16'h0000;
      f_push  <= 1'b0;
      f_word  <= 24'h000000;
    end
    else
    begin
      f_push <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          // skip leading zeros, one starts decoding
          if (lclk_rise && sdat)
          begin
            state   <= ST_HDR;
            bit_cnt <= 4'h0;
          end
        end
        ST_HDR:
        begin
          if (lclk_rise)
          begin
            hdr     <= {hdr[6:0], sdat};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'h7)
            begin
              bit_cnt <= 4'h0;
              addr    <= {hdr[4:0], sdat};
              case (hdr[6:5])
                `SECP_OP_READ:
                begin
                  // load word behind a dummy zero
                  out_sh <= {1'b0, mem[{hdr[4:0], sdat}]};
                  state  <= ST_RD;
                end
                `SECP_OP_WRITE:
                begin
                  kind  <= K_ONE;
                  state <= ST_DATA;
                end
                `SECP_OP_ERASE:
                begin
                  // erase is a write of all ones
                  kind  <= K_ONE;
                  pat   <= 16'hffff;
                  state <= ST_ARM;
                end
                default:
                begin
                  case (ext_of({hdr[6:0], sdat}))
                    `SECP_EXT_EN:
                    begin
                      prog_en <= 1'b1;
                      state   <= ST_WAIT;
                    end
                    `SECP_EXT_ERASE_ALL:
                    begin
                      kind  <= K_ALL;
                      pat   <= 16'hffff;
                      state <= ST_ARM;
                    end
                    `SECP_EXT_WRITE_ALL:
                    begin
                      kind  <= K_ALL;
                      state <= ST_DATA;
                    end
                    default:
                    begin
                      prog_en <= 1'b0;
                      state   <= ST_WAIT;
                    end
                  endcase
                end
              endcase
            end
          end
        end
        ST_RD:
        begin
          // shift only on a rising serial clock
          if (lclk_rise)
            out_sh <= {out_sh[15:0], 1'b1};
        end
        ST_DATA:
        begin
          if (lclk_rise)
          begin
            wdata   <= {wdata[14:0], sdat};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'hf)
            begin
              // data stored directly, no erase needed
              pat   <= {wdata[14:0], sdat};
              state <= ST_ARM;
            end
          end
        end
        ST_ARM:
        begin
          // falling chip select starts the cycle
          if (cs_fall)
          begin
            f_push <= prog_en & f_in_ready;
            f_word <= {kind, addr, pat};
          end
        end
        default:
          state <= ST_WAIT;
      endcase
      // any chip select low ends the frame; a new one needs a fresh rise
      if (!cs)
        state <= (state == ST_IDLE || state == ST_WAIT) ? ST_IDLE : ST_IDLE;
    end
  end

  // self-timed programming cycle, whole-array jobs sweep one word per clock
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      prog_cnt <= 32'h0;
      sweep    <= 7'h00;
      sweeping <= 1'b0;
      sweep_pat <= 16'h0000;
    end
    else if (f_valid && f_ready)
    begin
      prog_cnt <= PROG_CYCLES;
      // write_all covers the whole array
      // the queue head moves on after the pop, so the pattern is kept here
      if (f_data[23:22] == K_ALL)
      begin
        sweeping  <= 1'b1;
        sweep     <= 7'h00;
        sweep_pat <= f_data[15:0];
      end
      else
        mem[f_data[21:16]] <= f_data[15:0];
    end
    else
    begin
      if (prog_cnt != 32'h0)
        prog_cnt <= prog_cnt - 32'h1;
      if (sweeping)
      begin
        mem[sweep[5:0]] <= sweep_pat;
        sweep           <= sweep + 7'h01;
        if (sweep == 7'h3f)
          sweeping <= 1'b0;
      end
    end
  end

  // output pin: read data, else ready/busy status while selected
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end
    else
    begin
      serial_out_en <= cs & (state == ST_RD || state == ST_IDLE);
      // read data follows the shifter, updated on rising edges only
      if (state == ST_RD)
        serial_out <= out_sh[16];
      // status low while busy, high when ready
      else if (cs_rise || state == ST_IDLE)
        serial_out <= ~busy;
    end
  end
endmodule // secp_port

//--- test/secp_host.sv
// host model: drives select, link clock and data, and reads the data line
// assumes core_clk at 4 ns; the link clock runs at 48 ns only inside frames
`timescale 1ns/1ps
module secp_host (
  // clock
  input  wire core_clk,
  // device data line
  input  wire serial_out,
  input  wire serial_out_en,
  // host driven pins
  output reg  chip_select,
  output reg  serial_clock_in,
  output reg  serial_in
);
  reg  last;
  wire line;

  // a released line shows the inverse of its last value, never a stale copy
  assign line = serial_out_en ? serial_out : ~last;
  always @(posedge core_clk)
    if (serial_out_en)
      last <= serial_out;

  initial
  begin
    last            = 1'b0;
    chip_select     = 1'b0;
    serial_clock_in = 1'b0;
    serial_in       = 1'b0;
  end

  task wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // msb first shifting
  // data line is read late in the low phase, just before the rise, well after the previous rise settled
  task frame(input [31:0] bits, input int n, output [31:0] got);
    int i;
  begin
    got = 32'h0;
    chip_select <= 1'b1;
    wt(6);
    for (i = n - 1; i >= 0; i--)
    begin
      serial_in <= bits[i];
      wt(5);
      @(negedge core_clk);
      got[i] = line;
      wt(1);
      serial_clock_in <= 1'b1;
      wt(6);
      serial_clock_in <= 1'b0;
    end
  end
  endtask

  task drop;
  begin
    chip_select <= 1'b0;
    wt(64);
  end
  endtask

  // select again late
  // 128 cycles after the drop covers the 500 ns wait
  task poll(output logic first, output logic ready);
    int k;
  begin
    wt(64);
    chip_select <= 1'b1;
    wt(10);
    @(negedge core_clk);
    first = line;
    for (k = 0; k < 1000 && !line; k++)
      @(negedge core_clk);
    ready = line;
    wt(1);
  end
  endtask
endmodule // secp_host

//--- test/secp_port_chk.sv
// assertions on the ports of the serial word memory command port
// assumes it is bound to secp_port and that the host polls status long after a drop
`timescale 1ns/1ps
module secp_port_chk #(
  parameter PROG_CYCLES = 20
) (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // host pins
  input wire chip_select,
  input wire serial_clock_in,
  input wire serial_in,
  // device side
  input wire serial_out,
  input wire serial_out_en,
  input wire busy,
  input wire program_enabled
);
  reg        lclk_d;
  reg [7:0]  rise_age;
  reg [7:0]  drop_age;
  reg [15:0] busy_len;

  // ages since a link rise and a select drop saturate, so long idles stay harmless
  always @(posedge core_clk)
  begin
    lclk_d   <= serial_clock_in;
    busy_len <= busy ? busy_len + 16'h0001 : 16'h0000;
    if (reset || (serial_clock_in && !lclk_d))
      rise_age <= 8'h00;
    else if (rise_age != 8'hff)
      rise_age <= rise_age + 8'h01;
    if (reset || chip_select)
      drop_age <= 8'h00;
    else if (drop_age != 8'hff)
      drop_age <= drop_age + 8'h01;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_reset_state: assert property ($fell(reset) |-> !program_enabled && !busy)
    else $error("state after reset not idle and disabled");
  a_out_on_rise: assert property ($changed(serial_out) && serial_out_en && $past(serial_out_en)
    && !busy && !$past(busy) && !$past(busy, 2) && !$past(busy, 3) |-> rise_age <= 8)
    else $error("serial output moved without a link rise");
  a_busy_low: assert property (chip_select && $past(chip_select, 8) && busy && $past(busy, 4)
    && rise_age > 12 |-> !serial_out)
    else $error("status not low while busy");
  a_ready_high: assert property ($fell(busy) && chip_select && $past(chip_select, 8) |-> ##[1:4] serial_out)
    else $error("status not high after programming");
  a_prog_min: assert property ($fell(busy) |-> busy_len >= PROG_CYCLES - 1)
    else $error("programming cycle too short");
  a_prog_gated: assert property ($rose(busy) |-> $past(program_enabled))
    else $error("programming started while disabled");
  a_prog_on_drop: assert property ($rose(busy) |-> !chip_select && drop_age <= 12)
    else $error("programming not started by select drop");
  a_enable_held: assert property ($changed(program_enabled) |-> rise_age <= 10 || (!chip_select && drop_age <= 12))
    else $error("enable state changed outside a command");
endmodule // secp_port_chk

bind secp_port secp_port_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .core_clk        (core_clk),
  .reset           (reset),
  .chip_select     (chip_select),
  .serial_clock_in (serial_clock_in),
  .serial_in       (serial_in),
  .serial_out      (serial_out),
  .serial_out_en   (serial_out_en),
  .busy            (busy),
  .program_enabled (program_enabled)
);

//--- test/tb_secp_port.sv
// self-checking bench for the serial word memory command port
// assumes the host model and the bound checker are compiled before it
`timescale 1ns/1ps
`include "secp_defs.vh"
module tb_secp_port;
  // short programming time, still longer than the status wait
  localparam PROG = 400;
  reg  core_clk  = 1'b0;
  reg  reset     = 1'b1;
  wire chip_select;
  wire serial_clock_in;
  wire serial_in;
  wire serial_out;
  wire serial_out_en;
  wire busy;
  wire program_enabled;
  int  err_total = 0;
  int  cmp_count = 0;

  always #2 core_clk = ~core_clk;

  secp_port #(.PROG_CYCLES(PROG)) dut (
    .core_clk(core_clk), .reset(reset), .chip_select(chip_select), .serial_clock_in(serial_clock_in),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en), .busy(busy),
    .program_enabled(program_enabled));
  secp_host host (
    .core_clk(core_clk), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .chip_select(chip_select), .serial_clock_in(serial_clock_in), .serial_in(serial_in));

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
  begin
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  task test_done;
  begin
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  function [8:0] hd(input [1:0] op, input [5:0] a);
    hd = {1'b1, op, a};
  endfunction
  // don't-care bits set to a pattern so they are really ignored
  function [8:0] xh(input [1:0] sub);
    xh = {1'b1, `SECP_OP_EXT, sub, 4'ha};
  endfunction

  // one programming command, then a status poll on the data line
  task prog(input [8:0] h, input [15:0] d, input bit nd, input bit exp_busy);
    logic [31:0] got;
    logic        first;
    logic        ready;
  begin
    host.frame(nd ? {7'h00, h, d} : {23'h000000, h}, nd ? 25 : 9, got);
    host.drop;
    host.poll(first, ready);
    host.drop;
    chk("status first", 16'(first), {15'h0000, ~exp_busy});
    chk("status ready", 16'(ready), 16'h0001);
  end
  endtask

  task rd(input [5:0] a, input [15:0] exp, input int lead);
    logic [31:0] got;
  begin
    host.frame({6'h00, hd(`SECP_OP_READ, a), 17'h00000}, 26 + lead, got);
    host.drop;
    chk("dummy bit", 16'(got[16]), 16'h0000);
    chk("read word", got[15:0], exp);
  end
  endtask

  task t_power_up;
  begin
    chk("enabled", 16'(program_enabled), 16'h0000);
    prog(hd(`SECP_OP_WRITE, 6'h01), 16'h5555, 1'b1, 1'b0);
    chk("busy", 16'(busy), 16'h0000);
  end
  endtask

  task t_erase_all;
  begin
    prog(xh(`SECP_EXT_EN), 16'h0000, 1'b0, 1'b0);
    chk("enabled", 16'(program_enabled), 16'h0001);
    prog(xh(`SECP_EXT_ERASE_ALL), 16'h0000, 1'b0, 1'b1);
    rd(6'h00, 16'hffff, 0);
    rd(6'h3f, 16'hffff, 0);
  end
  endtask

  task t_write;
  begin
    prog(hd(`SECP_OP_WRITE, 6'h05), 16'h0f0f, 1'b1, 1'b1);
    prog(hd(`SECP_OP_WRITE, 6'h05), 16'hf0f0, 1'b1, 1'b1);
    rd(6'h05, 16'hf0f0, 3);
    rd(6'h06, 16'hffff, 0);
  end
  endtask

  task t_disabled;
  begin
    prog(xh(`SECP_EXT_DIS), 16'h0000, 1'b0, 1'b0);
    chk("enabled", 16'(program_enabled), 16'h0000);
    prog(hd(`SECP_OP_WRITE, 6'h05), 16'h1234, 1'b1, 1'b0);
    prog(hd(`SECP_OP_ERASE, 6'h05), 16'h0000, 1'b0, 1'b0);
    prog(xh(`SECP_EXT_WRITE_ALL), 16'h1234, 1'b1, 1'b0);
    prog(xh(`SECP_EXT_ERASE_ALL), 16'h0000, 1'b0, 1'b0);
    rd(6'h05, 16'hf0f0, 0);
  end
  endtask

  task t_erase_fill;
  begin
    prog(xh(`SECP_EXT_EN), 16'h0000, 1'b0, 1'b0);
    prog(hd(`SECP_OP_ERASE, 6'h05), 16'h0000, 1'b0, 1'b1);
    rd(6'h05, 16'hffff, 0);
    prog(xh(`SECP_EXT_WRITE_ALL), 16'h3c3c, 1'b1, 1'b1);
    rd(6'h00, 16'h3c3c, 0);
    rd(6'h3f, 16'h3c3c, 0);
    prog(xh(`SECP_EXT_DIS), 16'h0000, 1'b0, 1'b0);
  end
  endtask

  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_power_up;
    t_erase_all;
    t_write;
    t_disabled;
    t_erase_fill;
    test_done;
  end

  // watchdog, well beyond the expected run of about 10000 cycles
  initial
  begin
    #400000;
    err_total++;
    test_done;
  end
endmodule // tb_secp_port
